// [drq_irq_ctrl.sv]
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module drq_irq_ctrl
   import drq_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic far_end_present,
   input wire logic far_end_locked,
   input wire logic far_end_irq_pin,
   output logic host_irq,
   output logic evt_irq
);
   // Three-stage synchronisers; change accepted when stages 2 and 3 agree
   drq_link_type s1_r, s2_r, s3_r, link_r;
   always_ff @(posedge mclk) begin
      if (srst) begin
         s1_r <= 3'b001;
         s2_r <= 3'b001;
         s3_r <= 3'b001;
      end else begin
         s1_r <= {far_end_present, far_end_locked, far_end_irq_pin};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   // Pin idles high so no false remote request after reset
   always_ff @(posedge mclk) begin
      if (srst) begin
         link_r <= 3'b001;
      end else begin
         if (s2_r.present == s3_r.present) link_r.present <= s3_r.present;
         if (s2_r.locked == s3_r.locked) link_r.locked <= s3_r.locked;
         if (s2_r.irq_pin_n == s3_r.irq_pin_n)
            link_r.irq_pin_n <= s3_r.irq_pin_n;
      end
   end

   logic [7:0] config_r, control_r, evt_r, mask_r;
   logic presence_irq_flag, remote_irq_flag, global_flag;
   logic detect_cond, remote_cond;
   logic [7:0] status_v, isr_v;

   always_comb begin
      if (config_r[CFG_NEEDS_LOCK_BIT])
         detect_cond = link_r.present & link_r.locked;
      else
         detect_cond = link_r.present;
      remote_cond = ~link_r.irq_pin_n;
      presence_irq_flag = detect_cond & control_r[CTL_PRESENCE_EN_BIT];
      remote_irq_flag = remote_cond & control_r[CTL_REMOTE_EN_BIT];
      global_flag = presence_irq_flag | remote_irq_flag;
      status_v = STATUS_RST;
      status_v[STS_IRQ_PIN_BIT] = link_r.irq_pin_n;
      status_v[STS_LOCK_BIT] = link_r.locked;
      status_v[STS_PRESENT_BIT] = link_r.present;
      isr_v = 8'h00;
      isr_v[ISR_PRESENCE_BIT] = presence_irq_flag;
      isr_v[ISR_REMOTE_BIT] = remote_irq_flag;
      isr_v[ISR_GLOBAL_BIT] = global_flag;
   end

   // Single-cycle wait: request taken the cycle after it appears
   logic ack_r;
   logic req;
   assign req = (avs_read | avs_write) & ~ack_r;
   always_ff @(posedge mclk) begin
      if (srst) ack_r <= 1'b0;
      else ack_r <= req;
   end
   always_ff @(posedge mclk) begin
      if (srst) avs_waitrequest <= 1'b1;
      else avs_waitrequest <= ~req;
   end
   logic wr_en;
   assign wr_en = avs_write & ~avs_waitrequest;

   always_ff @(posedge mclk) begin
      if (srst) begin
         config_r <= CONFIG_RST;
         control_r <= CONTROL_RST;
         mask_r <= EVT_MASK_RST;
      end else if (wr_en) begin
         if (avs_address == OFS_CONFIG) config_r <= avs_writedata[7:0];
         if (avs_address == OFS_CONTROL) control_r <= avs_writedata[7:0];
         if (avs_address == OFS_EVT_MASK)
            mask_r <= avs_writedata[7:0] & EVT_USED;
      end
   end

   // Sticky rising-edge events; set wins over write-one-to-clear
   logic [7:0] evt_set, evt_clr;
   logic detect_d_r, remote_d_r;
   always_ff @(posedge mclk) begin
      if (srst) begin
         detect_d_r <= 1'b0;
         remote_d_r <= 1'b0;
      end else begin
         detect_d_r <= detect_cond;
         remote_d_r <= remote_cond;
      end
   end
   always_comb begin
      evt_set = 8'h00;
      evt_set[EVT_PRESENCE_BIT] = detect_cond & ~detect_d_r;
      evt_set[EVT_REMOTE_BIT] = remote_cond & ~remote_d_r;
      evt_clr = 8'h00;
      if (wr_en && avs_address == OFS_EVT_STATUS)
         evt_clr = avs_writedata[7:0] & EVT_USED;
   end
   always_ff @(posedge mclk) begin
      if (srst) evt_r <= 8'h00;
      else evt_r <= (evt_r & ~evt_clr) | evt_set;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         host_irq <= 1'b0;
         evt_irq <= 1'b0;
      end else begin
         host_irq <= control_r[CTL_GLOBAL_EN_BIT] & global_flag;
         evt_irq <= |(evt_r & mask_r);
      end
   end

   // Unmapped addresses read zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && req) begin
         unique case (avs_address)
            OFS_CONFIG: avs_readdata <= {24'h000000, config_r};
            OFS_STATUS: avs_readdata <= {24'h000000, status_v};
            OFS_CONTROL: avs_readdata <= {24'h000000, control_r};
            OFS_IRQ_STATUS: avs_readdata <= {24'h000000, isr_v};
            OFS_EVT_STATUS: avs_readdata <= {24'h000000, evt_r};
            OFS_EVT_MASK: avs_readdata <= {24'h000000, mask_r};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   chk_irq_gated: assert property (@(posedge mclk) disable iff (srst)
      !control_r[CTL_GLOBAL_EN_BIT] |=> !host_irq)
      else $error("host irq high with global enable clear");
   chk_irq_level: assert property (@(posedge mclk) disable iff (srst)
      host_irq == $past(control_r[CTL_GLOBAL_EN_BIT] & global_flag))
      else $error("host irq does not follow enabled sources");
   chk_detect_nolock: assert property (@(posedge mclk) disable iff (srst)
      (!config_r[CFG_NEEDS_LOCK_BIT] && link_r.present) |-> detect_cond)
      else $error("detect condition missing without lock select");
   chk_detect_lock: assert property (@(posedge mclk) disable iff (srst)
      (config_r[CFG_NEEDS_LOCK_BIT] && !link_r.locked) |-> !detect_cond)
      else $error("detect condition without lock");
   chk_pin_mirror: assert property (@(posedge mclk) disable iff (srst)
      status_v[STS_IRQ_PIN_BIT] == link_r.irq_pin_n)
      else $error("status pin bit mismatch");
   chk_lock_mirror: assert property (@(posedge mclk) disable iff (srst)
      status_v[STS_LOCK_BIT] == link_r.locked)
      else $error("status lock bit mismatch");
   chk_present_bit: assert property (@(posedge mclk) disable iff (srst)
      status_v[STS_PRESENT_BIT] == link_r.present)
      else $error("status present bit mismatch");
   chk_presence_en: assert property (@(posedge mclk) disable iff (srst)
      !control_r[CTL_PRESENCE_EN_BIT] |-> !isr_v[ISR_PRESENCE_BIT])
      else $error("presence flag while disabled");
   chk_remote_en: assert property (@(posedge mclk) disable iff (srst)
      (control_r[CTL_REMOTE_EN_BIT] && !link_r.irq_pin_n)
      |-> isr_v[ISR_REMOTE_BIT])
      else $error("remote flag missing");
   chk_global_flag: assert property (@(posedge mclk) disable iff (srst)
      isr_v[ISR_GLOBAL_BIT] == (isr_v[ISR_PRESENCE_BIT]
      | isr_v[ISR_REMOTE_BIT]))
      else $error("global flag mismatch");

   // Bus handshake: exactly one wait state, then one ready cycle
   chk_wait_answer: assert property (@(posedge mclk) disable iff (srst)
      req |=> !avs_waitrequest)
      else $error("no ready after request");

   chk_wait_one: assert property (@(posedge mclk) disable iff (srst)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("ready held longer than one cycle");

   chk_wait_idle: assert property (@(posedge mclk) disable iff (srst)
      !(avs_read || avs_write) |=> avs_waitrequest)
      else $error("ready without request");

   chk_wr_single: assert property (@(posedge mclk) disable iff (srst)
      wr_en |=> !wr_en)
      else $error("write taken twice in a row");

   chk_read_upper: assert property (@(posedge mclk) disable iff (srst)
      avs_readdata[31:8] == 24'h000000)
      else $error("upper read data not zero");

   chk_cfg_write: assert property (@(posedge mclk) disable iff (srst)
      (wr_en && avs_address == OFS_CONFIG)
      |=> config_r == $past(avs_writedata[7:0]))
      else $error("config write lost");

   chk_ctl_write: assert property (@(posedge mclk) disable iff (srst)
      (wr_en && avs_address == OFS_CONTROL)
      |=> control_r == $past(avs_writedata[7:0]))
      else $error("control write lost");

   chk_mask_write: assert property (@(posedge mclk) disable iff (srst)
      (wr_en && avs_address == OFS_EVT_MASK)
      |=> mask_r == $past(avs_writedata[7:0] & EVT_USED))
      else $error("mask write lost");

   chk_cfg_hold: assert property (@(posedge mclk) disable iff (srst)
      !(wr_en && avs_address == OFS_CONFIG) |=> $stable(config_r))
      else $error("config changed without write");

   chk_ctl_hold: assert property (@(posedge mclk) disable iff (srst)
      !(wr_en && avs_address == OFS_CONTROL) |=> $stable(control_r))
      else $error("control changed without write");

   // Source qualification
   chk_detect_full: assert property (@(posedge mclk) disable iff (srst)
      (config_r[CFG_NEEDS_LOCK_BIT] && link_r.present && link_r.locked)
      |-> detect_cond)
      else $error("detect missing with lock");

   chk_detect_absent: assert property (@(posedge mclk) disable iff (srst)
      !link_r.present |-> !detect_cond)
      else $error("detect without receiver");

   chk_remote_off: assert property (@(posedge mclk) disable iff (srst)
      !control_r[CTL_REMOTE_EN_BIT] |-> !isr_v[ISR_REMOTE_BIT])
      else $error("remote flag while disabled");

   chk_remote_idle: assert property (@(posedge mclk) disable iff (srst)
      link_r.irq_pin_n |-> !isr_v[ISR_REMOTE_BIT])
      else $error("remote flag with pin idle");

   chk_presence_on: assert property (@(posedge mclk) disable iff (srst)
      (control_r[CTL_PRESENCE_EN_BIT] && detect_cond)
      |-> isr_v[ISR_PRESENCE_BIT])
      else $error("presence flag missing");

   chk_irq_enabled: assert property (@(posedge mclk) disable iff (srst)
      (control_r[CTL_GLOBAL_EN_BIT] && global_flag) |=> host_irq)
      else $error("host irq missing while enabled");

   chk_global_off: assert property (@(posedge mclk) disable iff (srst)
      !isr_v[ISR_GLOBAL_BIT] |=> !host_irq)
      else $error("host irq without pending source");

   chk_status_spare: assert property (@(posedge mclk) disable iff (srst)
      (status_v & 8'h97) == 8'h00)
      else $error("status spare bits set");

   chk_isr_spare: assert property (@(posedge mclk) disable iff (srst)
      (isr_v & 8'h9E) == 8'h00)
      else $error("irq status spare bits set");

   chk_read_status: assert property (@(posedge mclk) disable iff (srst)
      (avs_read && req && avs_address == OFS_STATUS)
      |=> avs_readdata[7:0] == $past(status_v))
      else $error("status read mismatch");

   chk_read_isr: assert property (@(posedge mclk) disable iff (srst)
      (avs_read && req && avs_address == OFS_IRQ_STATUS)
      |=> avs_readdata[7:0] == $past(isr_v))
      else $error("irq status read mismatch");

   // Sticky events: set wins, clear only by a one
   chk_evt_set_det: assert property (@(posedge mclk) disable iff (srst)
      evt_set[EVT_PRESENCE_BIT] |=> evt_r[EVT_PRESENCE_BIT])
      else $error("detect event lost");

   chk_evt_set_rem: assert property (@(posedge mclk) disable iff (srst)
      evt_set[EVT_REMOTE_BIT] |=> evt_r[EVT_REMOTE_BIT])
      else $error("remote event lost");

   chk_evt_clear: assert property (@(posedge mclk) disable iff (srst)
      (evt_clr[EVT_PRESENCE_BIT] && !evt_set[EVT_PRESENCE_BIT])
      |=> !evt_r[EVT_PRESENCE_BIT])
      else $error("detect event not cleared");

   chk_evt_hold: assert property (@(posedge mclk) disable iff (srst)
      (evt_r[EVT_REMOTE_BIT] && !evt_clr[EVT_REMOTE_BIT])
      |=> evt_r[EVT_REMOTE_BIT])
      else $error("remote event dropped");

   chk_evt_unused: assert property (@(posedge mclk) disable iff (srst)
      (evt_r & ~EVT_USED) == 8'h00)
      else $error("unused event bit set");

   chk_evt_irq: assert property (@(posedge mclk) disable iff (srst)
      evt_irq == $past(|(evt_r & mask_r)))
      else $error("event irq does not follow mask");

   // Link filter holds while stages disagree
   chk_link_filter: assert property (@(posedge mclk) disable iff (srst)
      (s2_r.present != s3_r.present) |=> $stable(link_r.present))
      else $error("presence taken while unsettled");

endmodule : drq_irq_ctrl
`default_nettype wire

// [drq_pkg.sv]
package drq_pkg;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'hC2;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'hC4;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'hC6;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'hC7;
   localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'hC8;
   localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'hC9;
   localparam logic [7:0] CONFIG_RST = 8'h82;
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] EVT_MASK_RST = 8'h00;
   localparam int CFG_NEEDS_LOCK_BIT = 1;
   localparam int STS_IRQ_PIN_BIT = 6;
   localparam int STS_LOCK_BIT = 5;
   localparam int STS_PRESENT_BIT = 3;
   localparam int CTL_PRESENCE_EN_BIT = 6;
   localparam int CTL_REMOTE_EN_BIT = 5;
   localparam int CTL_GLOBAL_EN_BIT = 0;
   localparam int ISR_PRESENCE_BIT = 6;
   localparam int ISR_REMOTE_BIT = 5;
   localparam int ISR_GLOBAL_BIT = 0;
   localparam int EVT_PRESENCE_BIT = 0;
   localparam int EVT_REMOTE_BIT = 1;
   localparam logic [7:0] EVT_USED = 8'h03;
   typedef struct packed {
      logic present;
      logic locked;
      logic irq_pin_n;
   } drq_link_type;
endpackage : drq_pkg

// [drq_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
module drq_far_end
   import drq_pkg::*;
(
   input wire logic mclk,
   input wire logic [2:0] want,
   output drq_link_type link
);
   // Lock and pin mean nothing while detached; pin pulled up
   always_ff @(posedge mclk) begin
      link.present <= want[0];
      link.locked <= want[0] & want[1];
      link.irq_pin_n <= ~(want[0] & want[2]);
   end
endmodule : drq_far_end
`default_nettype wire

// [drq_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
   $display("BAD %0t got %h want %h", $time, a, b); end end
module testbench;
   import drq_pkg::*;
   logic mclk = 0, srst = 1, avs_read = 0, avs_write = 0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic avs_waitrequest, host_irq, evt_irq;
   logic [2:0] want = 3'h0;
   drq_link_type link;
   logic [31:0] exp_q[$];
   int n_errors = 0, check_count = 0, cyc = 0;
   logic [7:0] cfg, ctl;
   logic p, l, pn, q6, q5;
   drq_far_end far (.mclk(mclk), .want(want), .link(link));
   drq_irq_ctrl DUT (.mclk(mclk), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .far_end_present(link.present),
      .far_end_locked(link.locked), .far_end_irq_pin(link.irq_pin_n),
      .host_irq(host_irq), .evt_irq(evt_irq));
   initial forever #10 mclk = ~mclk;
   task automatic wrap_up;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 8000) begin
         n_errors++;
         wrap_up();
      end
   end
   // Read data only counts on the edge that ends the access
   // Pop once: the macro names its arguments twice
   logic [31:0] exp_rd;
   always @(posedge mclk)
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         exp_rd = exp_q.pop_front();
         `CHK(avs_readdata, exp_rd)
      end
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= {24'h0, d};
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) @(posedge mclk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({24'h0, e});
      bus(1'b0, a, 8'h00);
   endtask : rd
   initial begin
      void'($urandom(40));
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      rd(OFS_CONFIG, CONFIG_RST);
      rd(OFS_CONTROL, CONTROL_RST);
      rd(8'hC3, 8'h00);
      for (int i = 0; i < 128; i++) begin
         cfg = 8'($urandom);
         cfg[1] = i[0];
         ctl = (8'($urandom) & 8'h0E) | {1'b0, i[5], i[6], 4'h0, i[1]};
         want <= {i[4], i[3], i[2]};
         bus(1'b1, OFS_CONFIG, cfg);
         bus(1'b1, OFS_CONTROL, ctl);
         bus(1'b1, OFS_STATUS, 8'($urandom));
         // Long enough for the link synchroniser to settle
         repeat (8) @(posedge mclk);
         p = i[2];
         l = i[2] & i[3];
         pn = ~(i[2] & i[4]);
         q6 = i[5] & p & (l | ~i[0]);
         q5 = i[6] & ~pn;
         rd(OFS_CONFIG, cfg);
         rd(OFS_CONTROL, ctl & 8'h6F);
         rd(OFS_STATUS, {1'b0, pn, l, 1'b0, p, 3'h0});
         rd(OFS_IRQ_STATUS, {1'b0, q6, q5, 4'h0, q6 | q5});
         `CHK(host_irq, i[1] & (q6 | q5))
      end
      bus(1'b1, OFS_EVT_MASK, EVT_USED);
      want <= 3'h1;
      repeat (8) @(posedge mclk);
      bus(1'b1, OFS_EVT_STATUS, 8'h03);
      rd(OFS_EVT_STATUS, 8'h00);
      `CHK(evt_irq, 1'b0)
      want <= 3'h5;
      repeat (8) @(posedge mclk);
      rd(OFS_EVT_STATUS, 8'h02);
      `CHK(evt_irq, 1'b1)
      bus(1'b1, OFS_EVT_MASK, 8'h01);
      repeat (2) @(posedge mclk);
      `CHK(evt_irq, 1'b0)
      bus(1'b1, OFS_EVT_STATUS, 8'h02);
      rd(OFS_EVT_STATUS, 8'h00);
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
